// File: design/opfmt_pkg.sv
/*
  Shared constants for the address-modification engine and the operand
  formatter: word field positions, modifier and designator codes, tally
  variation codes, decimal sign codes and the engine state encoding.
  Assumes word bit 0 (most significant) sits at vector index 35.
*/
package opfmt_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int WORD_W  = 36;
  localparam int HALF_W  = 18;
  localparam int DWORD_W = 72;
  localparam int PTR_W   = 24;
  localparam int NUM_IDX = 8;
  localparam int FP_EXP_W    = 8;
  localparam int FP_MANT_S_W = 28;
  localparam int FP_MANT_D_W = 64;
  localparam logic signed [7:0] FP_EXP_MAX = 8'sh7F;
  localparam logic signed [7:0] FP_EXP_MIN = 8'sh80;
  // ---------------------------------------------------------------
  // instruction and indirect word fields
  // ---------------------------------------------------------------
  localparam int Y_MSB    = 35;
  localparam int Y_LSB    = 18;
  localparam int FUNC_MSB = 17;
  localparam int FUNC_LSB = 9;
  localparam int INH_BIT  = 8;
  localparam int PTR_BIT  = 6;
  localparam int TM_MSB   = 5;
  localparam int TM_LSB   = 4;
  localparam int TD_MSB   = 3;
  localparam int TD_LSB   = 0;
  localparam int TAL_MSB  = 17;
  localparam int TAL_LSB  = 6;
  localparam int CNINE_BIT = 3;
  localparam int DELTA_MSB = 5;
  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MOD_PLAIN_INDEX_MODE    = 2'h0,
    MOD_INDEX_THEN_DEREF    = 2'h1,
    MOD_TALLY_DEREF_MODE    = 2'h2,
    MOD_DEFERRED_INDEX_MODE = 2'h3
  } mod_t;
  localparam logic [3:0] TD_NONE            = 4'h0;
  localparam logic [3:0] TD_ACC_UPPER_PART  = 4'h1;
  localparam logic [3:0] TD_MQ_HIGH_PART    = 4'h2;
  localparam logic [3:0] TD_UPPER_IMMEDIATE = 4'h3;
  localparam logic [3:0] TD_PROGRAM_COUNTER = 4'h4;
  localparam logic [3:0] TD_ACC_LOW_PART    = 4'h5;
  localparam logic [3:0] TD_MQ_LOW_PART     = 4'h6;
  localparam logic [3:0] TD_LOWER_IMMEDIATE = 4'h7;
  localparam logic [3:0] TD_INDEX_REGS0     = 4'h8;
  localparam logic [3:0] TV_PLAIN              = 4'h0;
  localparam logic [3:0] TV_PREV_CHAR_SEQ      = 4'h5;
  localparam logic [3:0] TV_CHAR_VIA_POINTER   = 4'h8;
  localparam logic [3:0] TV_NEXT_CHAR_SEQ      = 4'hA;
  localparam logic [3:0] TV_DELTA_BUMP         = 4'hB;
  localparam logic [3:0] TV_STEP_DOWN_COUNT_UP = 4'hC;
  localparam logic [3:0] TV_STEP_UP_COUNT_DOWN = 4'hD;
  localparam logic [2:0] CHAR6_LAST = 3'h5;
  localparam logic [2:0] CHAR9_LAST = 3'h3;
  localparam logic [3:0] SIGN4_POS  = 4'hB;
  localparam logic [3:0] SIGN4_NEG  = 4'hD;
  localparam logic [8:0] SIGN9_POS  = 9'h02B;
  localparam logic [8:0] SIGN9_NEG  = 9'h02D;
  localparam logic [7:0] DEC_ZERO_EXP = 8'h7F;
  localparam logic [1:0] STR_WORD = 2'h0;
  localparam logic [1:0] STR_CHAR = 2'h1;
  localparam logic [1:0] STR_BIT  = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_EVAL  = 3'b001,
    ST_FETCH = 3'b010,
    ST_TALLY = 3'b011,
    ST_WRITE = 3'b100
  } seq_state_t;
endpackage

// File: design/operand_format.sv
/*
  Operand formatter: right-justifies characters, merges a stored character,
  extracts bit-string bits, splits binary floating words and decodes decimal
  signs and exponents. Inputs come from logic on the same clock.
*/
`timescale 1ns/100ps
module operand_format
  import opfmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [35:0] word_in,
  input  wire logic [8:0]  store_char,
  input  wire logic [1:0]  str_mode,
  input  wire logic [2:0]  cpos,
  input  wire logic        cnine,
  input  wire logic [4:0]  bit_idx,
  input  wire logic [2:0]  dig_pos,
  input  wire logic        mant_zero,
  output logic      [35:0] operand_out,
  output logic      [35:0] merged_out,
  output logic      [35:0] half_ext,
  output logic      [7:0]  fp_exp,
  output logic             fp_neg,
  output logic             bit_ok,
  output logic             sign_pos,
  output logic             sign_neg,
  output logic      [7:0]  dec_exp
);
  typedef struct packed {
    logic [35:0] operand;
    logic [35:0] merged;
    logic [35:0] half;
    logic [7:0]  fexp;
    logic        fneg;
    logic        bok;
    logic        spos;
    logic        sneg;
    logic [7:0]  dexp;
  } fmt_t;
  fmt_t r;
  fmt_t next_r;

  function automatic logic [3:0] digit(input logic [35:0] w, input logic [2:0] d);
    int b;
    b = 34 - 9 * int'(d[2:1]) - 4 * int'(d[0]);
    return w[b -: 4];
  endfunction

  // ---------------------------------------------------------------
  // formatting
  // ---------------------------------------------------------------
  always_comb begin
    logic [5:0] c6;
    logic [8:0] c9;
    logic [3:0] d0;
    logic [3:0] d1;
    c6 = word_in[35 - 6 * int'(cpos) -: 6];
    c9 = word_in[35 - 9 * int'(cpos[1:0]) -: 9];
    d0 = digit(word_in, dig_pos);
    d1 = (dig_pos == 3'h7) ? 4'h0 : digit(word_in, dig_pos + 3'h1);
    next_r = r;
    next_r.half = {{18{word_in[35]}}, word_in[35:18]};
    next_r.fexp = word_in[35:28];
    next_r.fneg = word_in[27];
    case (str_mode)
      STR_CHAR: next_r.operand = cnine ? {27'h0, c9} : {30'h0, c6};
      STR_BIT:  next_r.operand = {35'h0, word_in[34 - 9 * int'(bit_idx[4:3]) - int'(bit_idx[2:0])]};
      default:  next_r.operand = word_in;
    endcase
    next_r.merged = word_in;
    for (int p = 0; p < 6; p++) begin
      if (!cnine && p == int'(cpos)) begin
        next_r.merged[35 - 6 * p -: 6] = store_char[5:0];
      end
      if (cnine && p < 4 && p == int'(cpos)) begin
        next_r.merged[35 - 9 * p -: 9] = store_char;
      end
    end
    next_r.bok = ~|{word_in[35], word_in[26], word_in[17], word_in[8]};
    next_r.spos = cnine ? (c9 == SIGN9_POS) : (d0 == SIGN4_POS);
    next_r.sneg = cnine ? (c9 == SIGN9_NEG) : (d0 == SIGN4_NEG);
    // packed digits sit two to a character, exponent may straddle them
    next_r.dexp = mant_zero ? DEC_ZERO_EXP : (cnine ? c9[7:0] : {d0, d1});
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign operand_out = r.operand;
  assign merged_out  = r.merged;
  assign half_ext    = r.half;
  assign fp_exp      = r.fexp;
  assign fp_neg      = r.fneg;
  assign bit_ok      = r.bok;
  assign sign_pos    = r.spos;
  assign sign_neg    = r.sneg;
  assign dec_exp     = r.dexp;
endmodule

// File: design/addr_mod_engine.sv
/*
  Effective-address engine for single-word instructions, with the operand
  formatter beside it. Assumes the memory answers on the same clock and
  holds mem_ack high for one cycle per accepted request.
*/
`timescale 1ns/100ps
module addr_mod_engine
  import opfmt_pkg::*;
#(
  parameter int unsigned NUM_INDEX = NUM_IDX
)(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  inst_valid,
  input  wire logic [35:0]           inst_word,
  output logic                       inst_ready,
  input  wire logic [NUM_INDEX*18-1:0] index_regs,
  input  wire logic [35:0]           acc_word,
  input  wire logic [35:0]           mq_word,
  input  wire logic [17:0]           program_counter,
  input  wire logic [8*PTR_W-1:0]    pointer_regs,
  output logic                       mem_req,
  output logic                       mem_we,
  output logic      [17:0]           mem_addr,
  output logic      [35:0]           mem_wdata,
  input  wire logic                  mem_ack,
  input  wire logic [35:0]           mem_rdata,
  output logic                       ea_valid,
  output logic      [17:0]           ea,
  output logic                       ea_is_operand,
  output logic      [35:0]           imm_operand,
  output logic      [2:0]            char_pos,
  output logic                       char_nine,
  output logic                       tally_zero,
  output logic                       int_inhibit,
  output logic      [8:0]            function_code,
  output logic      [17:0]           subop_field,
  input  wire logic [35:0]           opnd_word,
  input  wire logic [8:0]            store_char,
  input  wire logic [1:0]            str_mode,
  input  wire logic [4:0]            bit_idx,
  input  wire logic [2:0]            dig_pos,
  input  wire logic                  mant_zero,
  output logic      [35:0]           operand_out,
  output logic      [35:0]           merged_out,
  output logic      [35:0]           half_ext,
  output logic      [7:0]            fp_exp,
  output logic                       fp_neg,
  output logic                       bit_ok,
  output logic                       sign_pos,
  output logic                       sign_neg,
  output logic      [7:0]            dec_exp
);
  if (NUM_INDEX != 8) begin : g_chk
    $error("designator decode serves exactly eight index registers");
  end

  typedef struct packed {
    seq_state_t  st;
    logic [35:0] word;
    logic [3:0]  td;
    logic [17:0] addr;
    logic [35:0] wdata;
    logic        defer;
    logic        kind;
    logic [17:0] ea;
    logic        imm;
    logic [35:0] operand;
    logic [2:0]  cpos;
    logic        cnine;
    logic        tzero;
    logic        inhibit;
    logic [8:0]  func;
    logic [17:0] subop;
    logic        done;
  } eng_t;
  eng_t r;
  eng_t next_r;

  // ---------------------------------------------------------------
  // index source decode
  // ---------------------------------------------------------------
  function automatic logic [17:0] idx_value(input logic [3:0] td);
    logic [17:0] v;
    v = 18'h0;
    case (td)
      TD_ACC_UPPER_PART:  v = acc_word[35:18];
      TD_ACC_LOW_PART:    v = acc_word[17:0];
      TD_MQ_HIGH_PART:    v = mq_word[35:18];
      TD_MQ_LOW_PART:     v = mq_word[17:0];
      TD_PROGRAM_COUNTER: v = program_counter;
      default: begin
        if (td[3]) begin
          v = index_regs[18 * int'(td[2:0]) +: 18];
        end
      end
    endcase
    return v;
  endfunction

  // pointer base plus sign-filled 15-bit offset; pointer stays unchanged
  function automatic logic [17:0] ptr_base(input logic [17:0] y);
    logic [23:0] p;
    p = pointer_regs[PTR_W * int'(y[17:15]) +: PTR_W];
    return p[23:6] + {{3{y[14]}}, y[14:0]};
  endfunction

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    logic [35:0] w;
    logic [17:0] y;
    logic [17:0] base;
    logic [17:0] sum;
    logic [1:0]  tm;
    logic [3:0]  td;
    logic        eval;
    logic        fin;
    logic [17:0] iy;
    logic [17:0] ny;
    logic [11:0] nt;
    logic [2:0]  np;
    logic [2:0]  last;
    logic        wb;
    logic        cnt;
    w    = (r.st == ST_IDLE) ? inst_word : r.word;
    y    = w[Y_MSB:Y_LSB];
    tm   = w[TM_MSB:TM_LSB];
    td   = w[TD_MSB:TD_LSB];
    base = (r.st == ST_IDLE && w[PTR_BIT]) ? ptr_base(y) : y;
    sum  = base + idx_value(td);
    eval = 1'h0;
    fin  = 1'h0;
    iy   = r.word[Y_MSB:Y_LSB];
    ny   = iy;
    nt   = r.word[TAL_MSB:TAL_LSB];
    np   = r.word[2:0];
    last = r.word[CNINE_BIT] ? CHAR9_LAST : CHAR6_LAST;
    wb   = 1'h0;
    cnt  = 1'h0;
    mem_req = 1'h0;
    mem_we  = 1'h0;
    next_r = r;
    next_r.done = 1'h0;
    case (r.st)
      ST_IDLE: begin
        if (inst_valid) begin
          next_r.inhibit = w[INH_BIT];
          next_r.func    = w[FUNC_MSB:FUNC_LSB];
          next_r.subop   = y;
          next_r.defer   = 1'h0;
          eval = 1'h1;
        end
      end
      ST_EVAL: eval = 1'h1;
      ST_FETCH: begin
        mem_req = 1'h1;
        if (mem_ack) begin
          next_r.word = mem_rdata;
          next_r.st   = r.kind ? ST_TALLY : ST_EVAL;
        end
      end
      ST_TALLY: begin
        next_r.ea    = iy;
        next_r.cpos  = np;
        next_r.cnine = r.word[CNINE_BIT];
        next_r.imm   = 1'h0;
        case (r.td)
          TV_STEP_UP_COUNT_DOWN: begin
            ny = iy + 18'h1;
            nt = nt - 12'h1;
            wb = 1'h1;
            cnt = 1'h1;
          end
          TV_STEP_DOWN_COUNT_UP: begin
            ny = iy - 18'h1;
            nt = nt + 12'h1;
            next_r.ea = ny;
            wb = 1'h1;
          end
          TV_NEXT_CHAR_SEQ: begin
            np = (np >= last) ? 3'h0 : np + 3'h1;
            ny = (np == 3'h0) ? iy + 18'h1 : iy;
            nt = nt - 12'h1;
            wb = 1'h1;
            cnt = 1'h1;
          end
          TV_PREV_CHAR_SEQ: begin
            np = (np == 3'h0) ? last : np - 3'h1;
            ny = (np == last) ? iy - 18'h1 : iy;
            nt = nt - 12'h1;
            next_r.ea   = ny;
            next_r.cpos = np;
            wb = 1'h1;
            cnt = 1'h1;
          end
          TV_DELTA_BUMP: begin
            ny = iy + {12'h0, r.word[DELTA_MSB:0]};
            nt = nt - 12'h1;
            wb = 1'h1;
            cnt = 1'h1;
          end
          default: wb = 1'h0; // plain indirect and character via pointer
        endcase
        next_r.tzero = cnt && (nt == 12'h0);
        next_r.wdata = {ny, nt, r.word[5:3], np};
        if (wb) begin
          next_r.st = ST_WRITE;
        end else begin
          next_r.st   = ST_IDLE;
          next_r.done = 1'h1;
        end
      end
      ST_WRITE: begin
        mem_req = 1'h1;
        mem_we  = 1'h1;
        if (mem_ack) begin
          next_r.st   = ST_IDLE;
          next_r.done = 1'h1;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    if (eval) begin
      // a flag left from an earlier chain must not end a fresh instruction
      if (r.st != ST_IDLE && r.defer && tm != MOD_DEFERRED_INDEX_MODE) begin
        fin = 1'h1;
      end else begin
        case (tm)
          MOD_INDEX_THEN_DEREF: begin
            next_r.addr = sum;
            next_r.kind = 1'h0;
            next_r.st   = ST_FETCH;
          end
          MOD_DEFERRED_INDEX_MODE: begin
            next_r.defer = 1'h1;
            next_r.addr  = base;
            next_r.kind  = 1'h0;
            next_r.st    = ST_FETCH;
          end
          MOD_TALLY_DEREF_MODE: begin
            next_r.addr = base;
            next_r.td   = td;
            next_r.kind = 1'h1;
            next_r.st   = ST_FETCH;
          end
          default: fin = 1'h1;
        endcase
      end
      if (fin) begin
        next_r.ea    = sum;
        next_r.imm   = (td == TD_UPPER_IMMEDIATE) || (td == TD_LOWER_IMMEDIATE);
        next_r.operand = (td == TD_UPPER_IMMEDIATE) ? {base, 18'h0} : {18'h0, base};
        next_r.cpos  = 3'h0;
        next_r.cnine = 1'h0;
        next_r.tzero = 1'h0;
        next_r.defer = 1'h0;
        next_r.st    = ST_IDLE;
        next_r.done  = 1'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign inst_ready    = (r.st == ST_IDLE);
  assign mem_addr      = r.addr;
  assign mem_wdata     = r.wdata;
  assign ea_valid      = r.done;
  assign ea            = r.ea;
  assign ea_is_operand = r.imm;
  assign imm_operand   = r.operand;
  assign char_pos      = r.cpos;
  assign char_nine     = r.cnine;
  assign tally_zero    = r.tzero;
  assign int_inhibit   = r.inhibit;
  assign function_code = r.func;
  assign subop_field   = r.subop;

  // ---------------------------------------------------------------
  // operand formatter
  // ---------------------------------------------------------------
  operand_format u_fmt (
    .clk         (clk),
    .rst_n       (rst_n),
    .word_in     (opnd_word),
    .store_char  (store_char),
    .str_mode    (str_mode),
    .cpos        (r.cpos),
    .cnine       (r.cnine),
    .bit_idx     (bit_idx),
    .dig_pos     (dig_pos),
    .mant_zero   (mant_zero),
    .operand_out (operand_out),
    .merged_out  (merged_out),
    .half_ext    (half_ext),
    .fp_exp      (fp_exp),
    .fp_neg      (fp_neg),
    .bit_ok      (bit_ok),
    .sign_pos    (sign_pos),
    .sign_neg    (sign_neg),
    .dec_exp     (dec_exp)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic [1:0] tm_in;
  assign take  = inst_valid && inst_ready;
  assign tm_in = inst_word[TM_MSB:TM_LSB];

  a_plain_one_cycle: assert property (take && tm_in == MOD_PLAIN_INDEX_MODE |=> ea_valid)
    else $error("plain indexing took extra cycles");
  a_plain_sum: assert property (take && tm_in == MOD_PLAIN_INDEX_MODE && !inst_word[PTR_BIT]
      && inst_word[3:0] == TD_INDEX_REGS0 |=> ea == $past(inst_word[35:18] + index_regs[17:0]))
    else $error("plain effective address wrong");
  a_lower_imm: assert property (take && tm_in == MOD_PLAIN_INDEX_MODE && !inst_word[PTR_BIT]
      && inst_word[3:0] == TD_LOWER_IMMEDIATE
      |=> ea_is_operand && imm_operand == {18'h0, $past(inst_word[35:18])})
    else $error("lower immediate operand wrong");
  a_ptr_offset: assert property (take && tm_in == MOD_PLAIN_INDEX_MODE && inst_word[PTR_BIT]
      && inst_word[3:0] == TD_NONE |=> ea == $past(ptr_base(inst_word[35:18])))
    else $error("pointer register base wrong");
  a_deref_addr: assert property (take && tm_in == MOD_INDEX_THEN_DEREF && !inst_word[PTR_BIT]
      && inst_word[3:0] == TD_INDEX_REGS0
      |=> mem_req && !mem_we && mem_addr == $past(inst_word[35:18] + index_regs[17:0]))
    else $error("index-then-deref fetch address wrong");
  a_tally_fetch: assert property (take && tm_in == MOD_TALLY_DEREF_MODE && !inst_word[PTR_BIT]
      |=> mem_req && !mem_we && mem_addr == $past(inst_word[35:18]))
    else $error("tally fetch address wrong");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before ack");
  a_inhibit_kept: assert property (take |=> int_inhibit == $past(inst_word[INH_BIT]))
    else $error("inhibit bit not carried");
  a_seq_advance: assert property (r.st == ST_TALLY && r.td == TV_NEXT_CHAR_SEQ
      && r.word[2:0] == 3'h0 |=> mem_we && mem_wdata[2:0] == 3'h1
      && mem_wdata[17:6] == $past(r.word[17:6]) - 12'h1)
    else $error("character sequence not advanced");
  a_plain_no_mem: assert property (take && tm_in == MOD_PLAIN_INDEX_MODE |=> !mem_req)
    else $error("plain mode touched memory");

  c_plain: cover property (take && tm_in == MOD_PLAIN_INDEX_MODE ##1 ea_valid);
  c_tally_wb: cover property (mem_req && mem_we && mem_ack ##1 ea_valid);
  c_defer_chain: cover property (r.defer && mem_ack ##1 r.st == ST_EVAL ##[1:5] r.st == ST_FETCH);
  c_tally_zero: cover property (ea_valid && tally_zero);
endmodule

// File: sim/mem_model.sv
/*
  Memory partner for the address engine: answers each request after lat
  wait cycles with a one-cycle mem_ack. Assumes one request at a time, held
  until mem_ack; read data is scrambled outside the ack cycle.
*/
`timescale 1ns/100ps
module mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [17:0] mem_addr,
  input  wire logic [35:0] mem_wdata,
  output logic             mem_ack,
  output logic      [35:0] mem_rdata
);
  logic [35:0] mem [0:255];
  logic [1:0]  cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 36'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (cnt >= lat) begin
          cnt <= 2'h0;
          mem_ack <= 1'b1;
          mem_rdata <= mem[mem_addr[7:0]];
          if (mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata;
          end
        end else begin
          cnt <= cnt + 2'h1;
        end
      end
    end
  end
endmodule

// File: sim/tb.sv
/*
  Testbench for addr_mod_engine with a memory partner.
  Assumes the field layout and codes of opfmt_pkg.
*/
`timescale 1ns/100ps
module tb;
  import opfmt_pkg::*;
  logic clk = 0, rst_n = 0, iv = 0, ack, req, we, ev, iop;
  logic [35:0] iw = 0, wd, rd, imm, oo, mo, ow = 0, acc = {18'h00001, 18'h00002}, mq = {18'h00003, 18'h00004};
  logic [17:0] addr, ea, pc = 18'h00005;
  logic [143:0] xr = 144'h0;
  logic [8:0] fc, sc = 0;
  logic [7:0] dx;
  logic [2:0] cp;
  logic [1:0] lat = 0, sm = 0;
  logic cn, tz, inh, mz = 0;
  int failures = 0, samples_checked = 0, cyc = 0, n, i;
  logic [3:0] tdv [5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
  logic [17:0] off [5] = '{18'h1, 18'h3, 18'h5, 18'h2, 18'h4};
  always #5 clk = ~clk;
  addr_mod_engine dut (.clk(clk), .rst_n(rst_n), .inst_valid(iv), .inst_word(iw), .inst_ready(),
    .index_regs(xr), .acc_word(acc), .mq_word(mq), .program_counter(pc), .pointer_regs(192'h0),
    .mem_req(req), .mem_we(we), .mem_addr(addr), .mem_wdata(wd), .mem_ack(ack), .mem_rdata(rd),
    .ea_valid(ev), .ea(ea), .ea_is_operand(iop), .imm_operand(imm), .char_pos(cp), .char_nine(cn),
    .tally_zero(tz), .int_inhibit(inh), .function_code(fc), .subop_field(), .opnd_word(ow),
    .store_char(sc), .str_mode(sm), .bit_idx(5'h0), .dig_pos(3'h0), .mant_zero(mz), .operand_out(oo),
    .merged_out(mo), .half_ext(), .fp_exp(), .fp_neg(), .bit_ok(), .sign_pos(), .sign_neg(), .dec_exp(dx));
  mem_model mem (.clk(clk), .rst_n(rst_n), .lat(lat), .mem_req(req), .mem_we(we), .mem_addr(addr),
    .mem_wdata(wd), .mem_ack(ack), .mem_rdata(rd));
  task chk(input string s, input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // offer one word, count cycles until ea_valid
  task run(input logic [35:0] w);
    @(posedge clk) #1 iv = 1;
    iw = w;
    @(posedge clk) #1 iv = 0;
    n = 1;
    while (ev !== 1'b1 && n < 60) begin
      @(posedge clk) #1 n++;
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      end_sim;
    end
  end
  initial begin
    xr[3*18+:18] = 18'h00100;
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    run({18'h00020, 9'h0AB, 3'b100, 2'h0, 4'hB});
    chk("plain_ea", 36'h120, ea);
    chk("plain_lat", 36'h1, n);
    chk("inhibit", 36'h1, inh);
    chk("func", 36'h0AB, fc);
    for (i = 0; i < 5; i++) begin
      run({18'h00040, 9'h0, 3'b000, 2'h0, tdv[i]});
      chk("src_ea", 18'h40 + off[i], ea);
    end
    run({18'h00007, 9'h0, 3'b000, 2'h0, 4'h7});
    chk("dl_op", 36'h1, iop);
    chk("dl_val", 36'h7, imm);
    $display("test plain done");
    lat = 2;
    mem.mem[16] = {18'h00050, 14'h0, 4'hB};
    run({18'h00010, 9'h0, 3'b000, 2'h3, 4'h0});
    chk("defer_ea", 36'h150, ea);
    $display("test deferred done");
    mem.mem[17] = {18'h00060, 12'h005, 3'b000, 3'h2};
    run({18'h00011, 9'h0, 3'b000, 2'h2, 4'hA});
    chk("tally_ea", 36'h60, ea);
    chk("tally_pos", 36'h2, cp);
    chk("tally_z", 36'h0, tz);
    chk("tally_wr", {18'h00060, 12'h004, 6'h03}, mem.mem[17]);
    $display("test tally done");
    ow = 36'h123456789;
    sm = 1;
    sc = 9'h03F;
    mz = 1;
    @(posedge clk) #1;
    chk("rd_char", {30'h0, ow[23:18]}, oo);
    chk("wr_char", {ow[35:24], 6'h3F, ow[17:0]}, mo);
    chk("zero_exp", 36'h7F, dx);
    $display("test format done");
    end_sim;
  end
endmodule
